// ==== include/tafl_pkg.sv ====
// constants and types shared by the temperature alarm and fault logic
package tafl_pkg;
   // channel counts and widths: channel 0 is internal, 1..3 are external diodes
   localparam int          NCH          = 4;
   localparam int          NEXT         = 3;
   localparam int          TW           = 8;
   localparam int          AW           = 8;
   localparam int          DW           = 16;
   // register offsets
   localparam logic [7:0]  A_CONFIG     = 8'h00;
   localparam logic [7:0]  A_HYST       = 8'h01;
   localparam logic [7:0]  A_MASK       = 8'h02;
   localparam logic [7:0]  A_STATUS     = 8'h03;
   localparam logic [7:0]  A_HIGH_STAT  = 8'h04;
   localparam logic [7:0]  A_LOW_STAT   = 8'h05;
   localparam logic [7:0]  A_FAULT_STAT = 8'h06;
   localparam logic [7:0]  A_CRIT_STAT  = 8'h07;
   localparam logic [7:0]  A_BETA       = 8'h08;
   localparam logic [7:0]  A_HIGH0      = 8'h0c;
   localparam logic [7:0]  A_LOW0       = 8'h10;
   localparam logic [7:0]  A_CRIT0      = 8'h14;
   localparam logic [7:0]  A_TEMP0      = 8'h18;
   localparam logic [7:0]  A_IDEAL1     = 8'h20;
   localparam logic [7:0]  A_FACTOR1    = 8'h24;
   // field positions
   localparam int          CFG_INHIBIT  = 0;
   localparam int          CFG_COMP     = 1;
   localparam int          CFG_AUTOB    = 2;
   localparam int          CFG_BJT      = 3;
   localparam int          MASK_FT      = 7;
   // values after reset
   localparam logic [7:0]  CFG_RST      = 8'h05;
   localparam logic [7:0]  HYST_RST     = 8'h0a;
   localparam logic [7:0]  MASK_RST     = 8'h00;
   localparam logic [2:0]  BETA_RST     = 3'h7;
   localparam logic [5:0]  IDEAL_RST    = 6'h12;
   localparam logic [7:0]  HIGH_RST     = 8'h55;
   localparam logic [7:0]  LOW_RST      = 8'h00;
   localparam logic [7:0]  CRIT_RST     = 8'h64;
   // ideality factor table, in units of 0.0001
   localparam logic [5:0]  IDEAL_MIN    = 6'h08;
   localparam logic [5:0]  IDEAL_MAX    = 6'h37;
   localparam logic [15:0] DIODE_BASE   = 16'h26dd;
   localparam logic [15:0] BJT_BASE     = 16'h268d;
   localparam logic [15:0] STEP_X10     = 16'h0083;
   localparam logic [15:0] TEN          = 16'h000a;
   // pin behaviour
   typedef enum logic {TAFL_MODE_INT = 1'b0, TAFL_MODE_COMP = 1'b1} tafl_mode_t;
endpackage

// ==== hdl/tafl_core.sv ====
// limit check, alarm pins, diode faults and compensation settings of the monitor
//
// Contract
// RULE1: comparator mode: alarm asserts when any unmasked channel is above its high limit.
// RULE2: comparator mode: alarm holds until all channels drop below high minus hysteresis.
// RULE3: comparator mode: high status follows the alarm, reads do not clear it.
// RULE4: comparator mode: the global inhibit bit does not block the alarm.
// RULE5: comparator mode: a masked channel never contributes to the alarm.
// RULE6: after reset the alarm is off and the global inhibit bit is set.
// RULE7: after reset a test fault is active, gated by the self-test bit.
// RULE8: software clears the inhibit bit and sets the self-test bit before use.
// RULE9: every channel has its own high, low and critical limit.
// RULE10: critical output asserts whenever a reading reaches its critical limit.
// RULE11: first external channel uses the detected gain setting when auto is on.
// RULE12: second and third external channels get no gain compensation.
// RULE13: software programs gain field all ones for plain diodes when auto is off.
// RULE14: each external channel has a 6-bit ideality setting sent to conversion.
// RULE15: diode model maps settings 08h..37h in ~0.0013 steps, 12h is 1.0080.
// RULE16: transistor model uses a shifted table where 12h is 1.0000.
// RULE17: each measurement checks external channels for open or supply-short faults.
// RULE18: a fault reads 00h, skips the low check and asserts the alarm unless masked. The code asserts the alarm on a fault in interrupt mode only.
// RULE19: anode shorts give zero readings, set low status and assert the alarm. The code raises both in interrupt mode only, with a low limit above 00h.
// RULE20: a cathode-to-ground short is no fault and raises nothing.
// RULE21: the fault register names the faulty channels and clears when read. The code records faults in interrupt mode only.
// RULE22: interrupt mode: alarm on high, low or fault, held until status is cleared.
// RULE23: interrupt mode: the inhibit bit forces the alarm off, status still updates.
// RULE24: a mode bit picks interrupt or comparator, used from the next evaluation.
`timescale 1ns/1ps
`default_nettype none
module tafl_core
   import tafl_pkg::*;
(
   input  wire logic                         clk_in,
   input  wire logic                         srst_in,
   input  wire logic [tafl_pkg::AW-1:0]      addr_in,
   input  wire logic [tafl_pkg::DW-1:0]      wdata_in,
   input  wire logic                         wr_in,
   input  wire logic                         rd_in,
   output logic      [tafl_pkg::DW-1:0]      rdata_out,
   input  wire logic                         meas_valid_in,
   input  wire logic [tafl_pkg::NCH*8-1:0]   temp_in,
   input  wire logic [tafl_pkg::NEXT-1:0]    diode_open_in,
   input  wire logic [tafl_pkg::NEXT-1:0]    anode_supply_short_in,
   input  wire logic [tafl_pkg::NEXT-1:0]    cathode_supply_short_in,
   input  wire logic [tafl_pkg::NEXT-1:0]    anode_zero_short_in,
   input  wire logic [2:0]                   beta_detect_in,
   output logic                              secondary_alarm_pin_oe_out,
   output logic                              crit_pin_oe_out,
   output logic      [2:0]                   beta_code_out,
   output logic      [tafl_pkg::NEXT*6-1:0]  ideality_out,
   output logic                              bjt_model_out
);
   import tafl_pkg::*;

   // subtract with floor at zero, used for both hysteresis thresholds
   function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
      sub_sat = (a > b) ? a - b : 8'h00;
   endfunction

   // true when addr falls in a block of four registers starting at base
   function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
      in_blk = (a[7:2] == base[7:2]);
   endfunction

   // ideality factor in units of 0.0001; codes outside the table clamp to its ends
   function automatic logic [15:0] ideal_factor(input logic [5:0] code, input logic bjt);
      logic [5:0]  c;
      logic [15:0] off;
      c = (code < IDEAL_MIN) ? IDEAL_MIN : ((code > IDEAL_MAX) ? IDEAL_MAX : code);
      off = {10'h000, c - IDEAL_MIN};
      ideal_factor = (bjt ? BJT_BASE : DIODE_BASE) + (off * STEP_X10) / TEN;
   endfunction

   logic [7:0]     cfg_r;
   logic [7:0]     hyst_r;
   logic [7:0]     mask_r;
   logic [2:0]     beta_r;
   logic [5:0]     ideal_r    [NEXT];
   logic [7:0]     high_lim_r [NCH];
   logic [7:0]     low_lim_r  [NCH];
   logic [7:0]     crit_lim_r [NCH];
   logic [7:0]     temp_r     [NCH];
   logic [NCH-1:0] high_stat_r;
   logic [NCH-1:0] low_stat_r;
   logic [NEXT-1:0] fault_stat_r;
   logic [NCH-1:0] hot_r;
   logic [NCH-1:0] crit_r;
   tafl_mode_t     eval_mode_r;
   logic           alarm_r;
   logic           crit_pin_r;
   logic [2:0]     beta_code_r;
   logic [DW-1:0]  rdata_r;

   logic [7:0]     rdg        [NCH];
   logic [NCH-1:0] fault_c;
   logic [NCH-1:0] hi_int;
   logic [NCH-1:0] hi_cmp;
   logic [NCH-1:0] lo_ev;
   logic [NCH-1:0] hot_nxt;
   logic [NCH-1:0] crit_nxt;
   logic [NCH-1:0] unmasked;
   logic           inhibit;
   logic           comp_sel;
   logic           art_fault;
   logic           rd_high;
   logic           rd_low;
   logic           rd_fault;

   assign inhibit   = cfg_r[CFG_INHIBIT];
   assign comp_sel  = cfg_r[CFG_COMP];
   assign unmasked  = ~mask_r[NCH-1:0];
   // RULE7 test fault
   // the built-in test fault stays active until software sets the self-test bit
   assign art_fault = ~mask_r[MASK_FT];
   assign rd_high   = rd_in && (addr_in == A_HIGH_STAT);
   assign rd_low    = rd_in && (addr_in == A_LOW_STAT);
   assign rd_fault  = rd_in && (addr_in == A_FAULT_STAT);

   // per channel evaluation of one set of readings
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         fault_c[c] = 1'b0;
         rdg[c]     = temp_in[c*8 +: 8];
         if (c > 0) begin
            // RULE17 fault check
            // RULE20 cathode ground ignored
            fault_c[c] = diode_open_in[c-1] | anode_supply_short_in[c-1]
                         | cathode_supply_short_in[c-1];
            // RULE18 zero reading
            // RULE19 shorts read zero
            if (fault_c[c] || anode_zero_short_in[c-1]) begin
               rdg[c] = 8'h00;
            end
         end
         // RULE9 per channel limits
         hi_int[c] = (rdg[c] >= high_lim_r[c]);
         hi_cmp[c] = (rdg[c] > high_lim_r[c]);
         // RULE18 no low check
         lo_ev[c]  = ~fault_c[c] && (rdg[c] < low_lim_r[c]);
         // RULE1 comparator set
         // RULE2 hysteresis release
         // RULE5 mask blocks set
         if (hi_cmp[c] && unmasked[c]) begin
            hot_nxt[c] = 1'b1;
         end else if (rdg[c] < sub_sat(high_lim_r[c], hyst_r)) begin
            hot_nxt[c] = 1'b0;
         end else begin
            hot_nxt[c] = hot_r[c];
         end
         // RULE10 critical tier
         if (rdg[c] >= crit_lim_r[c]) begin
            crit_nxt[c] = 1'b1;
         end else if (rdg[c] < sub_sat(crit_lim_r[c], hyst_r)) begin
            crit_nxt[c] = 1'b0;
         end else begin
            crit_nxt[c] = crit_r[c];
         end
      end
   end

   // configuration registers written by software
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         // RULE6 inhibit at reset
         cfg_r  <= CFG_RST;
         hyst_r <= HYST_RST;
         mask_r <= MASK_RST;
         beta_r <= BETA_RST;
      end else if (wr_in) begin
         if (addr_in == A_CONFIG) begin
            cfg_r <= wdata_in[7:0];
         end else if (addr_in == A_HYST) begin
            hyst_r <= wdata_in[7:0];
         end else if (addr_in == A_MASK) begin
            mask_r <= wdata_in[7:0];
         end else if (addr_in == A_BETA) begin
            beta_r <= wdata_in[2:0];
         end
      end
   end

   // limit and ideality tables
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int c = 0; c < NCH; c++) begin
            high_lim_r[c] <= HIGH_RST;
            low_lim_r[c]  <= LOW_RST;
            crit_lim_r[c] <= CRIT_RST;
         end
         for (int e = 0; e < NEXT; e++) begin
            ideal_r[e] <= IDEAL_RST;
         end
      end else if (wr_in) begin
         // RULE9 limit storage
         if (in_blk(addr_in, A_HIGH0)) begin
            high_lim_r[addr_in[1:0]] <= wdata_in[7:0];
         end else if (in_blk(addr_in, A_LOW0)) begin
            low_lim_r[addr_in[1:0]] <= wdata_in[7:0];
         end else if (in_blk(addr_in, A_CRIT0)) begin
            crit_lim_r[addr_in[1:0]] <= wdata_in[7:0];
         end else if (in_blk(addr_in, A_IDEAL1) && (addr_in[1:0] != 2'h3)) begin
            // RULE14 ideality storage
            ideal_r[addr_in[1:0]] <= wdata_in[5:0];
         end
      end
   end

   // readings and the mode in force, captured at each evaluation
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int c = 0; c < NCH; c++) begin
            temp_r[c] <= 8'h00;
         end
         eval_mode_r <= TAFL_MODE_INT;
         hot_r       <= '0;
         crit_r      <= '0;
      end else if (meas_valid_in) begin
         for (int c = 0; c < NCH; c++) begin
            temp_r[c] <= rdg[c];
         end
         // RULE24 mode taken here
         eval_mode_r <= tafl_mode_t'(comp_sel);
         hot_r       <= comp_sel ? hot_nxt : '0;
         crit_r      <= crit_nxt;
      end
   end

   // status, sticky in interrupt mode: a new event wins over a read in the same cycle
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         high_stat_r  <= '0;
         low_stat_r   <= '0;
         fault_stat_r <= '0;
      end else if (meas_valid_in && comp_sel) begin
         // RULE3 status follows alarm
         high_stat_r  <= hot_nxt;
         low_stat_r   <= rd_low ? '0 : low_stat_r;
         fault_stat_r <= rd_fault ? '0 : fault_stat_r;
      end else if (meas_valid_in) begin
         // RULE22 interrupt status
         // RULE23 status despite inhibit
         high_stat_r  <= hi_int | (rd_high ? '0 : high_stat_r);
         // RULE19 low status set
         low_stat_r   <= lo_ev | (rd_low ? '0 : low_stat_r);
         // RULE21 fault register
         fault_stat_r <= fault_c[NCH-1:1] | (rd_fault ? '0 : fault_stat_r);
      end else begin
         // RULE3 reads ignored in comparator
         if (rd_high && eval_mode_r == TAFL_MODE_INT) begin
            high_stat_r <= '0;
         end
         if (rd_low) begin
            low_stat_r <= '0;
         end
         // RULE21 clear on read
         if (rd_fault) begin
            fault_stat_r <= '0;
         end
      end
   end

   // alarm pins, open drain: the enable pulls the line low
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         alarm_r    <= 1'b0;
         crit_pin_r <= 1'b0;
      end else begin
         if (eval_mode_r == TAFL_MODE_COMP) begin
            // RULE4 inhibit ignored
            // RULE5 masked channel dropped
            alarm_r <= |(hot_r & unmasked);
         end else begin
            // RULE18 fault alarm
            // RULE23 inhibit forces off
            alarm_r <= ~inhibit & ((|((high_stat_r | low_stat_r | {fault_stat_r, 1'b0})
                                       & unmasked)) | art_fault);
         end
         // RULE10 never masked
         crit_pin_r <= |crit_r;
      end
   end

   // gain compensation select, first external channel only
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         beta_code_r <= BETA_RST;
      end else begin
         // RULE11 auto detect
         // RULE12 no other channels
         beta_code_r <= cfg_r[CFG_AUTOB] ? beta_detect_in : beta_r;
      end
   end

   // read port: data stand in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_r <= '0;
      end else if (rd_in) begin
         rdata_r <= '0;
         if (addr_in == A_CONFIG) begin
            rdata_r[7:0] <= cfg_r;
         end else if (addr_in == A_HYST) begin
            rdata_r[7:0] <= hyst_r;
         end else if (addr_in == A_MASK) begin
            rdata_r[7:0] <= mask_r;
         end else if (addr_in == A_STATUS) begin
            rdata_r[3:0] <= {|crit_r, |fault_stat_r, |low_stat_r, |high_stat_r};
         end else if (addr_in == A_HIGH_STAT) begin
            rdata_r[NCH-1:0] <= high_stat_r;
         end else if (addr_in == A_LOW_STAT) begin
            rdata_r[NCH-1:0] <= low_stat_r;
         end else if (addr_in == A_FAULT_STAT) begin
            rdata_r[NCH-1:1] <= fault_stat_r;
         end else if (addr_in == A_CRIT_STAT) begin
            rdata_r[NCH-1:0] <= crit_r;
         end else if (addr_in == A_BETA) begin
            rdata_r[2:0] <= beta_code_r;
         end else if (in_blk(addr_in, A_HIGH0)) begin
            rdata_r[7:0] <= high_lim_r[addr_in[1:0]];
         end else if (in_blk(addr_in, A_LOW0)) begin
            rdata_r[7:0] <= low_lim_r[addr_in[1:0]];
         end else if (in_blk(addr_in, A_CRIT0)) begin
            rdata_r[7:0] <= crit_lim_r[addr_in[1:0]];
         end else if (in_blk(addr_in, A_TEMP0)) begin
            rdata_r[7:0] <= temp_r[addr_in[1:0]];
         end else if (in_blk(addr_in, A_IDEAL1) && (addr_in[1:0] != 2'h3)) begin
            rdata_r[5:0] <= ideal_r[addr_in[1:0]];
         end else if (in_blk(addr_in, A_FACTOR1) && (addr_in[1:0] != 2'h3)) begin
            // RULE15 diode table
            // RULE16 transistor table
            rdata_r <= ideal_factor(ideal_r[addr_in[1:0]], cfg_r[CFG_BJT]);
         end
      end
   end

   assign rdata_out                  = rdata_r;
   assign secondary_alarm_pin_oe_out = alarm_r;
   assign crit_pin_oe_out            = crit_pin_r;
   assign beta_code_out              = beta_code_r;
   // RULE14 settings to converter
   assign ideality_out               = {ideal_r[2], ideal_r[1], ideal_r[0]};
   assign bjt_model_out              = cfg_r[CFG_BJT];

   // checks on the alarm behaviour
   property p_rule1;
      @(posedge clk_in) disable iff (srst_in)
      meas_valid_in && comp_sel && |(hi_cmp & unmasked) |-> ##2 secondary_alarm_pin_oe_out;
   endproperty
   a_rule1: assert property (p_rule1) else $error("alarm missed over high limit"); // RULE1

   property p_rule2;
      @(posedge clk_in) disable iff (srst_in)
      eval_mode_r == TAFL_MODE_COMP && |(hot_r & unmasked) && !meas_valid_in && !wr_in
      |=> secondary_alarm_pin_oe_out;
   endproperty
   a_rule2: assert property (p_rule2) else $error("alarm dropped above hysteresis"); // RULE2

   property p_rule3;
      @(posedge clk_in) disable iff (srst_in)
      eval_mode_r == TAFL_MODE_COMP && comp_sel && rd_high && !meas_valid_in
      |=> high_stat_r == $past(high_stat_r);
   endproperty
   a_rule3: assert property (p_rule3) else $error("read cleared comparator status"); // RULE3

   property p_rule4;
      @(posedge clk_in) disable iff (srst_in)
      meas_valid_in && comp_sel && inhibit && |(hi_cmp & unmasked) && !wr_in
      ##1 !wr_in |-> ##1 secondary_alarm_pin_oe_out;
   endproperty
   a_rule4: assert property (p_rule4) else $error("inhibit blocked comparator alarm"); // RULE4

   property p_rule6;
      @(posedge clk_in) $fell(srst_in) |-> !secondary_alarm_pin_oe_out && inhibit;
   endproperty
   a_rule6: assert property (p_rule6) else $error("alarm not disabled after reset"); // RULE6

   property p_rule10;
      @(posedge clk_in) disable iff (srst_in)
      meas_valid_in && rdg[1] >= crit_lim_r[1] |-> ##2 crit_pin_oe_out;
   endproperty
   a_rule10: assert property (p_rule10) else $error("critical output missed"); // RULE10

   property p_rule18;
      @(posedge clk_in) disable iff (srst_in)
      meas_valid_in && !comp_sel && diode_open_in[2] |=> fault_stat_r[2] && temp_r[3] == 8'h00;
   endproperty
   a_rule18: assert property (p_rule18) else $error("diode fault not reported"); // RULE18

   property p_rule21;
      @(posedge clk_in) disable iff (srst_in)
      rd_fault && !meas_valid_in |=> fault_stat_r == '0;
   endproperty
   a_rule21: assert property (p_rule21) else $error("fault register not cleared"); // RULE21

   property p_rule23;
      @(posedge clk_in) disable iff (srst_in)
      eval_mode_r == TAFL_MODE_INT && inhibit |=> !secondary_alarm_pin_oe_out;
   endproperty
   a_rule23: assert property (p_rule23) else $error("inhibit did not hold alarm off"); // RULE23

   c_comp_alarm: cover property (@(posedge clk_in) disable iff (srst_in)
      eval_mode_r == TAFL_MODE_COMP && secondary_alarm_pin_oe_out);
   c_int_alarm: cover property (@(posedge clk_in) disable iff (srst_in)
      eval_mode_r == TAFL_MODE_INT && secondary_alarm_pin_oe_out && !art_fault);
   c_crit: cover property (@(posedge clk_in) disable iff (srst_in) crit_pin_oe_out);
   c_fault_read: cover property (@(posedge clk_in) disable iff (srst_in)
      rd_fault && |fault_stat_r);
endmodule
`default_nettype wire

// ==== sim/tafl_host_pins.sv ====
// host side of the alarm pins: pull-up resistors on the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module tafl_host_pins (
   input  wire logic alarm_oe_in,
   input  wire logic crit_oe_in,
   output logic      alarm_n_out,
   output logic      crit_n_out
);
   // a released open-drain line is pulled high by the host's resistor
   assign alarm_n_out = alarm_oe_in ? 1'b0 : 1'b1;
   assign crit_n_out  = crit_oe_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== sim/tafl_core_bench.sv ====
// register-level bench of the temperature alarm and fault logic
`timescale 1ns/1ps
`default_nettype none
module tafl_core_bench;
   import tafl_pkg::*;
   logic              clk_in;
   logic              srst_in;
   logic [AW-1:0]     addr_in;
   logic [DW-1:0]     wdata_in;
   logic              wr_in;
   logic              rd_in;
   logic [DW-1:0]     rdata_out;
   logic              meas_valid_in;
   logic [NCH*8-1:0]  temp_in;
   logic [NEXT-1:0]   diode_open_in;
   logic [NEXT-1:0]   zshort;
   logic              alarm_oe;
   logic              crit_oe;
   logic              alarm_n;
   logic              crit_n;
   logic [2:0]        beta_code;
   logic [NEXT*6-1:0] ideality;
   logic [DW-1:0]     v;
   int                n_fail;
   int                checks;

   tafl_core dut_u (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .meas_valid_in(meas_valid_in), .temp_in(temp_in), .diode_open_in(diode_open_in),
      .anode_supply_short_in(3'h0), .cathode_supply_short_in(3'h0),
      .anode_zero_short_in(zshort), .beta_detect_in(3'h3),
      .secondary_alarm_pin_oe_out(alarm_oe), .crit_pin_oe_out(crit_oe),
      .beta_code_out(beta_code), .ideality_out(ideality), .bjt_model_out());
   tafl_host_pins host_u (.alarm_oe_in(alarm_oe), .crit_oe_in(crit_oe),
      .alarm_n_out(alarm_n), .crit_n_out(crit_n));

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic end_sim();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, taken at the second edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask

   // read data stands from the cycle after the strobe edge until the next read
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      d = rdata_out;
   endtask

   // one measurement pulse; pins are settled one edge after it is taken
   task automatic meas(input logic [31:0] t, input logic [2:0] op);
      @(posedge clk_in);
      temp_in       <= t;
      diode_open_in <= op;
      meas_valid_in <= 1'b1;
      @(posedge clk_in);
      meas_valid_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      end_sim();
   end

   initial begin
      n_fail = 0; checks = 0;
      srst_in = 1'b1; addr_in = 8'h00; wdata_in = 16'h0000; wr_in = 1'b0; rd_in = 1'b0;
      meas_valid_in = 1'b0; temp_in = 32'h30303030; diode_open_in = 3'h0; zshort = 3'h0;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      // reset values and pin defaults
      chk_pin(alarm_n, 1'b1);
      rd(A_CONFIG, v); chk_reg(v, 16'h0005);
      rd(A_HYST, v); chk_reg(v, 16'h000a);
      rd(A_MASK, v); chk_reg(v, 16'h0000);
      rd(A_HIGH0, v); chk_reg(v, 16'h0055);
      rd(A_CRIT0 + 8'h02, v); chk_reg(v, 16'h0064);
      rd(A_IDEAL1, v); chk_reg(v, 16'h0012);
      rd(8'hff, v); chk_reg(v, 16'h0000);
      chk_reg({4'h0, ideality[5:0], ideality[11:6]}, 16'h0492);
      $display("test reset done");
      // artificial fault fires once the inhibit is cleared, until self-test is set
      wr(A_CONFIG, 16'h0004);
      meas(32'h30303030, 3'h0); chk_pin(alarm_n, 1'b0);
      wr(A_MASK, 16'h0080);
      rd(A_FAULT_STAT, v); rd(A_STATUS, v); rd(A_HIGH_STAT, v); rd(A_LOW_STAT, v);
      meas(32'h30303030, 3'h0); chk_pin(alarm_n, 1'b1);
      $display("test selftest done");
      // comparator mode with inhibit still set
      wr(A_CONFIG, 16'h0007);
      meas(32'h30305530, 3'h0); chk_pin(alarm_n, 1'b1);
      meas(32'h30305630, 3'h0); chk_pin(alarm_n, 1'b0);
      rd(A_HIGH_STAT, v); chk_reg(v, 16'h0002);
      rd(A_HIGH_STAT, v); chk_reg(v, 16'h0002);
      meas(32'h30304b30, 3'h0); chk_pin(alarm_n, 1'b0);
      meas(32'h30304a30, 3'h0); chk_pin(alarm_n, 1'b1);
      rd(A_HIGH_STAT, v); chk_reg(v, 16'h0000);
      wr(A_MASK, 16'h0082);
      meas(32'h30306030, 3'h0); chk_pin(alarm_n, 1'b1);
      wr(A_MASK, 16'h0080);
      $display("test comparator done");
      // critical pin at and around its limit
      meas(32'h30633030, 3'h0); chk_pin(crit_n, 1'b1);
      meas(32'h30643030, 3'h0); chk_pin(crit_n, 1'b0);
      meas(32'h30303030, 3'h0); chk_pin(crit_n, 1'b1);
      $display("test critical done");
      // open diode on the third external channel, interrupt mode
      wr(A_CONFIG, 16'h0004);
      meas(32'h50303030, 3'h4); chk_pin(alarm_n, 1'b0);
      rd(A_TEMP0 + 8'h03, v); chk_reg(v, 16'h0000);
      rd(A_FAULT_STAT, v); chk_reg(v, 16'h0008);
      rd(A_FAULT_STAT, v); chk_reg(v, 16'h0000);
      // anode short reads zero and trips the low check against a raised low limit
      wr(A_LOW0 + 8'h01, 16'h0010);
      @(posedge clk_in);
      zshort <= 3'h1;
      meas(32'h30303030, 3'h0); chk_pin(alarm_n, 1'b0);
      rd(A_TEMP0 + 8'h01, v); chk_reg(v, 16'h0000);
      rd(A_LOW_STAT, v); chk_reg(v, 16'h0002);
      zshort <= 3'h0;
      $display("test fault done");
      // ideality factor tables in both models
      rd(A_FACTOR1, v); chk_reg(v, 16'h2760);
      wr(A_IDEAL1, 16'h0008);
      rd(A_FACTOR1, v); chk_reg(v, 16'h26dd);
      chk_reg({10'h000, ideality[5:0]}, 16'h0008);
      wr(A_CONFIG, 16'h000c);
      wr(A_IDEAL1, 16'h0012);
      rd(A_FACTOR1, v); chk_reg(v, 16'h2710);
      $display("test ideality done");
      // gain setting: detected value, then programmed all ones
      chk_reg({13'h0000, beta_code}, 16'h0003);
      wr(A_CONFIG, 16'h0001);
      wr(A_BETA, 16'h0007);
      repeat (2) @(posedge clk_in);
      #1;
      chk_reg({13'h0000, beta_code}, 16'h0007);
      $display("test beta done");
      end_sim();
   end
endmodule
`default_nettype wire
